// [hdl/aiu_set0_front.sv]
// Set 0 register front end of the advanced IR serial port with FIFOs, DMA and interrupt gating.
//
// Summary of operation
// R1 - Bank select enable turns on advanced mode
// R2 - Set select reachable from every set
// R3 - Sets 0/1 shared, sets 2-7 advanced only
// R4 - Sets 1-7 hold divisor, version, others
// R5 - Set 0 decodes eight byte offsets
// R6 - Offset 0 reads receive, writes transmit
// R7 - Legacy mode uses programmed I/O only
// R8 - Fast IR modes give separate DMA channels
// R9 - Swap bit exchanges transmit and receive channels
// R10 - Receive-only channel enable gives single channel
// R11 - Legacy enable bits 7-4 read zero
// R12 - Enable bit 7 gates timer interrupt
// R13 - Bit 6 frame FIFO, medium/fast IR only
// R14 - Bit 5 gates transmit threshold interrupt
// R15 - Bit 4 gates DMA terminal count
// R16 - Bit 3 handshake, needs IR handshake select
// R17 - Bit 2 line status in serial IR
// R18 - Bit 2 adds underrun in fast modes
// R19 - Bit 1 gates transmit empty interrupt
// R20 - Advanced: 32-entry FIFOs, per-source status
// R21 - Bit 0 gates receive threshold interrupt
// R22 - Set codes decode; line control sets 0/1
// R23 - Interrupt needs true condition and enable
`timescale 1ns/1ps
module aiu_set0_front
	import aiu_pkg::*;
#(
	parameter logic [7:0] VERSION_ID = 8'h5A // Arbitrary identification value.
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Register port.
	input wire aiu_reg_req_type reg_req_i,
	output logic [7:0] reg_rdata_o,
	// Configuration levels.
	input wire logic bank_select_enable_i,
	input wire aiu_dma_cfg_type dma_cfg_i,
	input wire aiu_mode_type ir_mode_i,
	input wire logic ir_handshake_select_i,
	// Line side status.
	input wire aiu_src_type src_i,
	input wire logic [7:0] line_status_i,
	input wire logic [7:0] handshake_status_i,
	// Line side data streams.
	input wire logic [7:0] rx_data_i,
	input wire logic rx_valid_i,
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	// DMA handshake.
	input wire logic [1:0] dma_ack_i,
	input wire logic [7:0] dma_data_i,
	output logic [1:0] dma_req_o,
	output logic [7:0] dma_data_o,
	// Interrupt.
	output logic irq_o
);

	logic [7:0] set_sel_ff, line_ctrl_ff, ier_ff, fcr_ff, hcr_ff, scratch_ff;
	logic [7:0] div_lo_ff, div_hi_ff, adv_ctrl_ff;
	logic [7:0] tx_mem [FIFO_DEPTH];
	logic [7:0] rx_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] tx_wr_ff, tx_rd_ff, rx_wr_ff, rx_rd_ff;
	logic [CNT_W-1:0] tx_cnt_ff, rx_cnt_ff, limit;
	logic [7:0] tx_data_ff, dma_data_ff, rdata_ff, nxt_rdata;
	logic tx_valid_ff, irq_ff, dma_tc_ff;
	logic [1:0] dma_req_ff, nxt_dma_req;
	logic [2:0] cur_set;
	logic adv, dma_mode, frame_mode, ir_on, swap;
	logic wr, rd, s0, host_tx_push, host_rx_pop, dma_tx_ack, dma_rx_ack;
	logic tx_full, tx_push, tx_pop, rx_full, rx_push, rx_pop, tx_rst, rx_rst;
	logic [7:0] tx_push_data, rx_head, stat, act, ier_view;
	logic [3:0] iid;

	// Mode flags; the bank select bit is the single switch into advanced operation.
	assign adv = bank_select_enable_i; // R1
	assign dma_mode = adv && (ir_mode_i inside {MODE_MIR, MODE_FIR, MODE_RC}); // R8
	assign frame_mode = adv && (ir_mode_i inside {MODE_MIR, MODE_FIR});
	assign ir_on = ir_mode_i != MODE_UART;
	assign swap = adv_ctrl_ff[ADV_SWAP_BIT];

	// Set decode; advanced set codes only count while the bank is open.
	always_comb begin
		cur_set = SET_1;
		if (!set_sel_ff[SSR_BANK_BIT]) begin
			cur_set = SET_0; // R22
		end else if (adv) begin
			unique case (set_sel_ff) // R3
				SSR_CODE_S2: cur_set = SET_2;
				SSR_CODE_S3: cur_set = SET_3;
				SSR_CODE_S4: cur_set = SET_4;
				SSR_CODE_S5: cur_set = SET_5;
				SSR_CODE_S6: cur_set = SET_6;
				SSR_CODE_S7: cur_set = SET_7;
				default: cur_set = SET_1;
			endcase
		end
	end

	// Access strobes for the data port and the FIFO reset commands.
	assign wr = reg_req_i.wr;
	assign rd = reg_req_i.rd;
	assign s0 = cur_set == SET_0;
	assign host_tx_push = wr && s0 && reg_req_i.addr == OFF_DATA; // R6
	assign host_rx_pop = rd && s0 && reg_req_i.addr == OFF_DATA; // R6
	assign tx_rst = wr && s0 && reg_req_i.addr == OFF_ISR && reg_req_i.wdata[FCR_TXRST];
	assign rx_rst = wr && s0 && reg_req_i.addr == OFF_ISR && reg_req_i.wdata[FCR_RXRST];

	// DMA acknowledges are routed to a direction by the swap bit; legacy ignores them.
	assign dma_tx_ack = dma_mode && (swap ? dma_ack_i[CH_B] : dma_ack_i[CH_A]); // R9
	assign dma_rx_ack = dma_mode && (swap ? dma_ack_i[CH_A] : dma_ack_i[CH_B]); // R7

	// FIFO depth is 32 in advanced mode and 16 in legacy.
	assign limit = adv ? ADV_LIMIT : LEG_LIMIT; // R20
	assign tx_full = tx_cnt_ff >= limit;
	assign rx_full = rx_cnt_ff >= limit;
	assign tx_push = (host_tx_push || dma_tx_ack) && !tx_full;
	assign tx_push_data = host_tx_push ? reg_req_i.wdata : dma_data_i;
	assign tx_pop = tx_cnt_ff != '0 && (!tx_valid_ff || tx_ready_i);
	assign rx_push = rx_valid_i && !rx_full;
	assign rx_pop = (host_rx_pop || dma_rx_ack) && rx_cnt_ff != '0;
	assign rx_head = rx_mem[rx_rd_ff];

	// Transmit FIFO storage; a host write wins over a DMA write in the same cycle.
	always_ff @(posedge clock_i) begin
		if (tx_push) begin
			tx_mem[tx_wr_ff] <= tx_push_data;
		end
	end

	// Transmit FIFO pointers; the reset command flushes it in one cycle.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || tx_rst) begin
			tx_wr_ff <= '0;
			tx_rd_ff <= '0;
			tx_cnt_ff <= '0;
		end else begin
			if (tx_push) begin
				tx_wr_ff <= tx_wr_ff + 1'b1;
			end
			if (tx_pop) begin
				tx_rd_ff <= tx_rd_ff + 1'b1;
			end
			tx_cnt_ff <= CNT_W'(tx_cnt_ff + tx_push - tx_pop);
		end
	end

	// Output stage toward the line; it holds a byte until the line takes it.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			tx_valid_ff <= 1'b0;
			tx_data_ff <= RST_BYTE;
		end else if (tx_pop) begin
			tx_valid_ff <= 1'b1;
			tx_data_ff <= tx_mem[tx_rd_ff];
		end else if (tx_ready_i) begin
			tx_valid_ff <= 1'b0;
		end
	end

	// Receive FIFO storage; bytes arriving while full are dropped.
	always_ff @(posedge clock_i) begin
		if (rx_push) begin
			rx_mem[rx_wr_ff] <= rx_data_i;
		end
	end

	// Receive FIFO pointers.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || rx_rst) begin
			rx_wr_ff <= '0;
			rx_rd_ff <= '0;
			rx_cnt_ff <= '0;
		end else begin
			if (rx_push) begin
				rx_wr_ff <= rx_wr_ff + 1'b1;
			end
			if (rx_pop) begin
				rx_rd_ff <= rx_rd_ff + 1'b1;
			end
			rx_cnt_ff <= CNT_W'(rx_cnt_ff + rx_push - rx_pop);
		end
	end

	// DMA requests are levels; with only the receive channel enabled, channel B alone serves.
	always_comb begin
		nxt_dma_req[CH_A] = dma_mode && dma_cfg_i.tx_en && (swap ? rx_cnt_ff != '0 : !tx_full); // R8
		nxt_dma_req[CH_B] = dma_mode && dma_cfg_i.rx_en && (swap ? !tx_full : rx_cnt_ff != '0); // R10
	end

	// DMA request flops and data returned to the controller.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			dma_req_ff <= 2'h0;
			dma_data_ff <= RST_BYTE;
		end else begin
			dma_req_ff <= nxt_dma_req; // R7
			if (dma_rx_ack && rx_cnt_ff != '0) begin
				dma_data_ff <= rx_head;
			end
		end
	end

	// Terminal count is sticky until the status is read; a new count wins over the clear.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			dma_tc_ff <= 1'b0;
		end else if (src_i.dma_tc) begin
			dma_tc_ff <= 1'b1;
		end else if (rd && s0 && reg_req_i.addr == OFF_ISR && adv) begin
			dma_tc_ff <= 1'b0;
		end
	end

	// One status bit per source, each a live condition except the sticky DMA terminal count.
	always_comb begin
		stat[IE_TMR] = src_i.timer_zero;
		stat[IE_FSF] = frame_mode && src_i.fsf_level;
		stat[IE_TXTH] = tx_cnt_ff < TX_LVL[fcr_ff[FCR_TXLVL_LO +: 2]];
		stat[IE_DMA] = dma_tc_ff;
		stat[IE_HS] = src_i.hs_change;
		stat[IE_LS] = src_i.line_err || (dma_mode && src_i.tx_underrun); // R18
		stat[IE_TXE] = tx_cnt_ff == '0 && !tx_valid_ff;
		stat[IE_RX] = adv ? rx_cnt_ff >= RX_LVL[fcr_ff[FCR_RXLVL_LO +: 2]] : rx_cnt_ff != '0;
	end

	// Each source reaches the output only while its condition and its enable are both true.
	always_comb begin
		act[IE_TMR] = adv && ier_ff[IE_TMR] && stat[IE_TMR]; // R12
		act[IE_FSF] = frame_mode && ier_ff[IE_FSF] && stat[IE_FSF]; // R13
		act[IE_TXTH] = adv && ier_ff[IE_TXTH] && stat[IE_TXTH]; // R14
		act[IE_DMA] = dma_mode && ier_ff[IE_DMA] && stat[IE_DMA]; // R15
		act[IE_HS] = ier_ff[IE_HS] && stat[IE_HS] && (!ir_on || ir_handshake_select_i); // R16
		act[IE_LS] = ier_ff[IE_LS] && stat[IE_LS]; // R17
		act[IE_TXE] = ier_ff[IE_TXE] && stat[IE_TXE]; // R19
		act[IE_RX] = ier_ff[IE_RX] && stat[IE_RX]; // R21
	end

	// Interrupt output flop; no latching, so a cleared enable drops it next cycle.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |act; // R23
		end
	end

	// Legacy identification code in fixed priority order.
	always_comb begin
		if (act[IE_LS]) begin
			iid = IID_LS;
		end else if (act[IE_RX]) begin
			iid = IID_RX;
		end else if (act[IE_TXE]) begin
			iid = IID_TXE;
		end else if (act[IE_HS]) begin
			iid = IID_HS;
		end else begin
			iid = IID_NONE;
		end
	end

	// Upper enables are hidden outside advanced mode even if set before the switch.
	assign ier_view = adv ? ier_ff : (ier_ff & IE_LEGACY_MASK); // R11

	// Set select shares offset 3 in every set; line control only takes writes in sets 0 and 1.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			set_sel_ff <= RST_BYTE;
			line_ctrl_ff <= RST_BYTE;
		end else if (wr && reg_req_i.addr == OFF_LCR) begin
			set_sel_ff <= reg_req_i.wdata; // R2
			if (cur_set == SET_0 || cur_set == SET_1) begin
				line_ctrl_ff <= reg_req_i.wdata; // R22
			end
		end
	end

	// Set 0 control registers; legacy writes cannot set the upper enables.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ier_ff <= RST_BYTE;
			fcr_ff <= RST_BYTE;
			hcr_ff <= RST_BYTE;
			scratch_ff <= RST_BYTE;
		end else if (wr && s0) begin
			unique case (reg_req_i.addr) // R5
				OFF_IER: ier_ff <= adv ? reg_req_i.wdata : (reg_req_i.wdata & IE_LEGACY_MASK); // R11
				OFF_ISR: fcr_ff <= reg_req_i.wdata & FCR_STORE_MASK;
				OFF_HCR: hcr_ff <= reg_req_i.wdata;
				OFF_SCR: scratch_ff <= reg_req_i.wdata;
				default: ;
			endcase
		end
	end

	// Divisor in set 1 and the advanced control byte in set 2.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			div_lo_ff <= RST_BYTE;
			div_hi_ff <= RST_BYTE;
			adv_ctrl_ff <= RST_BYTE;
		end else if (wr) begin
			if (cur_set == SET_1 && reg_req_i.addr == OFF_DATA) begin
				div_lo_ff <= reg_req_i.wdata; // R4
			end
			if (cur_set == SET_1 && reg_req_i.addr == OFF_IER) begin
				div_hi_ff <= reg_req_i.wdata; // R4
			end
			if (cur_set == SET_2 && reg_req_i.addr == OFF_ISR) begin
				adv_ctrl_ff <= reg_req_i.wdata; // R9
			end
		end
	end

	// Read multiplexer; unmapped locations read zero.
	always_comb begin
		nxt_rdata = RST_BYTE;
		if (reg_req_i.addr == OFF_LCR) begin
			nxt_rdata = (cur_set == SET_0 || cur_set == SET_1) ? line_ctrl_ff : set_sel_ff;
		end else if (s0) begin
			unique case (reg_req_i.addr) // R5
				OFF_DATA: nxt_rdata = rx_head; // R6
				OFF_IER: nxt_rdata = ier_view;
				OFF_ISR: nxt_rdata = adv ? stat : {{2{fcr_ff[FCR_EN]}}, 2'h0, iid}; // R20
				OFF_HCR: nxt_rdata = hcr_ff;
				OFF_LSR: nxt_rdata = line_status_i;
				OFF_HSR: nxt_rdata = handshake_status_i;
				OFF_SCR: nxt_rdata = scratch_ff;
				default: nxt_rdata = RST_BYTE;
			endcase
		end else if (cur_set == SET_1 && reg_req_i.addr == OFF_DATA) begin
			nxt_rdata = div_lo_ff;
		end else if (cur_set == SET_1 && reg_req_i.addr == OFF_IER) begin
			nxt_rdata = div_hi_ff;
		end else if (cur_set == SET_2 && reg_req_i.addr == OFF_ISR) begin
			nxt_rdata = adv_ctrl_ff;
		end else if (cur_set == SET_3 && reg_req_i.addr == OFF_DATA) begin
			nxt_rdata = VERSION_ID; // R4
		end
	end

	// Read data stands for exactly the cycle after the read strobe.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rdata_ff <= RST_BYTE;
		end else begin
			rdata_ff <= rd ? nxt_rdata : RST_BYTE;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign tx_data_o = tx_data_ff;
	assign tx_valid_o = tx_valid_ff;
	assign dma_req_o = dma_req_ff;
	assign dma_data_o = dma_data_ff;
	assign irq_o = irq_ff;

	// Checks on the block's own behaviour.
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	AST_LEGACY_NO_DMA: assert property (!dma_mode |=> dma_req_o == 2'h0) // R7
		else $error("DMA request driven outside DMA modes");
	AST_IER_UPPER_ZERO: assert property (rd && !adv && s0 && reg_req_i.addr == OFF_IER // R11
		|=> reg_rdata_o[7:4] == 4'h0)
		else $error("Legacy enable read shows upper bits");
	AST_ENABLE_CLEAR: assert property (wr && s0 && reg_req_i.addr == OFF_IER // R23
		&& reg_req_i.wdata == 8'h00 |=> ##1 !irq_o)
		else $error("Interrupt stays high after enables cleared");
	AST_SWAP: assert property (dma_mode && swap && !tx_full && dma_cfg_i.rx_en // R9
		|=> dma_req_o[CH_B])
		else $error("Swapped transmit need not shown on channel B");
	AST_SINGLE: assert property (dma_cfg_i.rx_en && !dma_cfg_i.tx_en |=> !dma_req_o[CH_A]) // R10
		else $error("Disabled transmit channel requested");
	AST_SSR_ANYSET: assert property (wr && reg_req_i.addr == OFF_LCR // R2
		&& reg_req_i.wdata == 8'h00 |=> cur_set == SET_0)
		else $error("Set select write did not return to set 0");
	AST_LCR_LOCK: assert property (wr && reg_req_i.addr == OFF_LCR && cur_set > SET_1 // R22
		|=> $stable(line_ctrl_ff))
		else $error("Line control changed outside sets 0 and 1");
	AST_RX_READ: assert property (host_rx_pop && rx_cnt_ff != '0 // R6
		|=> reg_rdata_o == $past(rx_head) && rx_cnt_ff == $past(rx_cnt_ff) - 1'b1 + $past(rx_push))
		else $error("Receive read returned wrong byte or count");
	AST_BANK_CLOSED: assert property (!adv && wr && reg_req_i.addr == OFF_LCR // R1
		&& reg_req_i.wdata[SSR_BANK_BIT] ##1 !adv |-> cur_set == SET_1)
		else $error("Advanced set reached with bank closed");

	CVR_SET7: cover property (adv && cur_set == SET_7);
	CVR_DMA_SWAP: cover property (dma_mode && swap && dma_req_o[CH_B]);
	CVR_TX_FULL: cover property (adv && tx_cnt_ff == ADV_LIMIT);
	CVR_IRQ: cover property (adv && act[IE_TMR] ##1 irq_o);

endmodule // aiu_set0_front

// [hdl/aiu_pkg.sv]
// Package with constants, modes and carriers of the advanced IR serial port set 0 front end.
package aiu_pkg;

	// Register offsets within a set.
	localparam logic [2:0] OFF_DATA = 3'h0;
	localparam logic [2:0] OFF_IER = 3'h1;
	localparam logic [2:0] OFF_ISR = 3'h2;
	localparam logic [2:0] OFF_LCR = 3'h3;
	localparam logic [2:0] OFF_HCR = 3'h4;
	localparam logic [2:0] OFF_LSR = 3'h5;
	localparam logic [2:0] OFF_HSR = 3'h6;
	localparam logic [2:0] OFF_SCR = 3'h7;

	// Set numbers and set-select codes.
	localparam logic [2:0] SET_0 = 3'h0;
	localparam logic [2:0] SET_1 = 3'h1;
	localparam logic [2:0] SET_2 = 3'h2;
	localparam logic [2:0] SET_3 = 3'h3;
	localparam logic [2:0] SET_4 = 3'h4;
	localparam logic [2:0] SET_5 = 3'h5;
	localparam logic [2:0] SET_6 = 3'h6;
	localparam logic [2:0] SET_7 = 3'h7;
	localparam int SSR_BANK_BIT = 7;
	localparam logic [7:0] SSR_CODE_S2 = 8'hE0;
	localparam logic [7:0] SSR_CODE_S3 = 8'hE4;
	localparam logic [7:0] SSR_CODE_S4 = 8'hE8;
	localparam logic [7:0] SSR_CODE_S5 = 8'hEC;
	localparam logic [7:0] SSR_CODE_S6 = 8'hF0;
	localparam logic [7:0] SSR_CODE_S7 = 8'hF4;

	// Interrupt enable bit positions.
	localparam int IE_TMR = 7;
	localparam int IE_FSF = 6;
	localparam int IE_TXTH = 5;
	localparam int IE_DMA = 4;
	localparam int IE_HS = 3;
	localparam int IE_LS = 2;
	localparam int IE_TXE = 1;
	localparam int IE_RX = 0;
	localparam logic [7:0] IE_LEGACY_MASK = 8'h0F;

	// FIFO control fields and advanced control fields.
	localparam int FCR_EN = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int FCR_TXLVL_LO = 4;
	localparam int FCR_RXLVL_LO = 6;
	localparam logic [7:0] FCR_STORE_MASK = 8'hF1;
	localparam int ADV_SWAP_BIT = 3;

	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;

	// FIFO geometry and thresholds, indexed by the two-bit level code.
	localparam int FIFO_DEPTH = 32;
	localparam int PTR_W = 5;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] ADV_LIMIT = 6'h20;
	localparam logic [CNT_W-1:0] LEG_LIMIT = 6'h10;
	localparam logic [3:0][CNT_W-1:0] RX_LVL = {6'h1A, 6'h10, 6'h04, 6'h01};
	localparam logic [3:0][CNT_W-1:0] TX_LVL = {6'h19, 6'h11, 6'h07, 6'h01};

	// Legacy encoded interrupt identification.
	localparam logic [3:0] IID_NONE = 4'h1;
	localparam logic [3:0] IID_LS = 4'h6;
	localparam logic [3:0] IID_RX = 4'h4;
	localparam logic [3:0] IID_TXE = 4'h2;
	localparam logic [3:0] IID_HS = 4'h0;

	// DMA channel indices.
	localparam int CH_A = 0;
	localparam int CH_B = 1;

	typedef enum logic [2:0] {MODE_UART, MODE_SIR, MODE_ASK, MODE_MIR, MODE_FIR, MODE_RC} aiu_mode_type;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} aiu_reg_req_type;

	typedef struct packed {
		logic tx_en;
		logic rx_en;
	} aiu_dma_cfg_type;

	typedef struct packed {
		logic timer_zero;
		logic fsf_level;
		logic hs_change;
		logic line_err;
		logic tx_underrun;
		logic dma_tc;
	} aiu_src_type;

endpackage

// [verif/aiu_line_model.sv]
// Line-side partner model: takes transmitted bytes and delivers received bytes.
`timescale 1ns/1ps
module aiu_line_model (
	// Clock.
	input wire logic clock_i,
	// Transmit stream from the device.
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	// Receive stream into the device.
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	// Behaviour control.
	input wire logic slow_i
);
	logic [7:0] got_q[$];
	logic ready_ff = 1'b0;
	logic [7:0] rx_data_ff = 8'hFF;
	logic rx_valid_ff = 1'b0;

	// Outputs start idle with a non-zero data pattern; each has a single writer.
	assign tx_ready_o = ready_ff;
	assign rx_data_o = rx_data_ff;
	assign rx_valid_o = rx_valid_ff;

	// A slow line toggles ready, so the device must hold its byte until it is taken.
	always @(posedge clock_i) begin
		ready_ff <= slow_i ? ~ready_ff : 1'b1;
		if (tx_valid_i && ready_ff) begin
			got_q.push_back(tx_data_i);
		end
	end

	// One received byte for one cycle; afterwards the data lines show the inverse.
	task automatic send_rx(input logic [7:0] b);
		@(posedge clock_i);
		rx_data_ff <= b;
		rx_valid_ff <= 1'b1;
		@(posedge clock_i);
		rx_valid_ff <= 1'b0;
		rx_data_ff <= ~b;
	endtask
endmodule // aiu_line_model

// [verif/tb.sv]
// Self-checking testbench of the set 0 front end with a line-side partner.
`timescale 1ns/1ps
module tb;
	import aiu_pkg::*;
	localparam logic [7:0] VER = 8'h5A; // Arbitrary identification value.
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	aiu_reg_req_type req = '0;
	logic [7:0] rdata;
	logic bank = 1'b0;
	aiu_dma_cfg_type dcfg = '0;
	aiu_mode_type mode = MODE_UART;
	logic hs_sel = 1'b0;
	aiu_src_type src = '0;
	logic [7:0] lsr_in = 8'hA5;
	logic [7:0] hsr_in = 8'h3C;
	logic [7:0] rx_data, tx_data, dma_rdata, rd_val;
	logic rx_valid, tx_valid, tx_ready, irq;
	logic slow = 1'b0;
	logic [1:0] dma_ack = 2'h0;
	logic [7:0] dma_wdata = 8'h00;
	logic [1:0] dma_req;
	int mismatches = 0;
	int n_tests = 0;

	// Clock of 25 ns period.
	always #12.5 clock_i = ~clock_i;

	aiu_set0_front #(.VERSION_ID(VER)) i_dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
		.bank_select_enable_i(bank), .dma_cfg_i(dcfg), .ir_mode_i(mode),
		.ir_handshake_select_i(hs_sel), .src_i(src), .line_status_i(lsr_in),
		.handshake_status_i(hsr_in), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
		.tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
		.dma_ack_i(dma_ack), .dma_data_i(dma_wdata), .dma_req_o(dma_req),
		.dma_data_o(dma_rdata), .irq_o(irq)
	);

	aiu_line_model i_line (
		.clock_i(clock_i), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid), .slow_i(slow)
	);

	// Counts a comparison and reports a mismatch at once.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Lets n edges pass and samples just after the last one.
	task automatic settle(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	// One-cycle register write.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_i);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clock_i);
		req.wr <= 1'b0;
	endtask

	// One-cycle register read; the data stand only in the following cycle.
	task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clock_i);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clock_i);
		req.rd <= 1'b0;
		#1;
		rd_val = rdata;
		check(rd_val, exp);
	endtask

	// Waits a bounded time for the line to take a byte.
	task automatic wait_tx(input logic [7:0] exp);
		int i;
		for (i = 0; i < 100 && i_line.got_q.size() == 0; i++) begin
			@(posedge clock_i);
		end
		if (i_line.got_q.size() == 0) begin
			mismatches++;
			test_done();
		end else begin
			check(i_line.got_q.pop_front(), exp);
		end
	endtask

	// One-cycle acknowledge on the given channels, as a DMA controller gives it.
	task automatic ack(input logic [1:0] ch);
		@(posedge clock_i);
		dma_ack <= ch;
		@(posedge clock_i);
		dma_ack <= 2'h0;
		#1;
	endtask

	// Legacy register map: masked enables, scratch, pass-through status, no DMA.
	task automatic t_legacy();
		check({6'h0, dma_req}, 8'h00);
		check({7'h0, irq}, 8'h00);
		chk_rd(OFF_IER, 8'h00);
		wr(OFF_IER, 8'hFF);
		chk_rd(OFF_IER, 8'h0F);
		chk_rd(OFF_ISR, 8'h02);
		check({7'h0, irq}, 8'h01);
		wr(OFF_SCR, 8'h96);
		chk_rd(OFF_SCR, 8'h96);
		wr(OFF_HCR, 8'h0B);
		chk_rd(OFF_HCR, 8'h0B);
		wr(OFF_LSR, 8'h00);
		chk_rd(OFF_LSR, lsr_in);
		chk_rd(OFF_HSR, hsr_in);
		wr(OFF_IER, 8'h00);
		@(posedge clock_i);
		mode <= MODE_FIR;
		dcfg <= 2'b11;
		settle(3);
		check({6'h0, dma_req}, 8'h00);
	endtask

	// Set selection from the shared register, in both modes.
	task automatic t_sets();
		wr(OFF_LCR, SSR_CODE_S3);
		chk_rd(OFF_DATA, 8'h00);
		wr(OFF_DATA, 8'h0C);
		chk_rd(OFF_DATA, 8'h0C);
		wr(OFF_LCR, 8'h00);
		@(posedge clock_i);
		bank <= 1'b1;
		wr(OFF_LCR, SSR_CODE_S3);
		chk_rd(OFF_DATA, VER);
		wr(OFF_LCR, 8'h03);
		chk_rd(OFF_SCR, 8'h96);
		chk_rd(OFF_LCR, SSR_CODE_S3);
		wr(OFF_LCR, 8'h03);
		chk_rd(OFF_LCR, 8'h03);
	endtask

	// Data port with a slow line: reads give received bytes, never the transmit byte.
	task automatic t_data();
		slow <= 1'b1;
		i_line.send_rx(8'h5E);
		wr(OFF_DATA, 8'hC3);
		chk_rd(OFF_DATA, 8'h5E);
		wait_tx(8'hC3);
		slow <= 1'b0;
	endtask

	// DMA requests per channel, the swap and the single-channel setup.
	task automatic t_dma();
		settle(3);
		check({6'h0, dma_req}, 8'h01);
		i_line.send_rx(8'h77);
		settle(3);
		check({6'h0, dma_req}, 8'h03);
		ack(2'b10);
		check(dma_rdata, 8'h77);
		wr(OFF_LCR, SSR_CODE_S2);
		wr(OFF_ISR, 8'h08);
		wr(OFF_LCR, 8'h03);
		settle(3);
		check({6'h0, dma_req}, 8'h02);
		@(posedge clock_i);
		dcfg <= 2'b01;
		dma_wdata <= 8'h3C;
		settle(3);
		check({6'h0, dma_req}, 8'h02);
		ack(2'b10);
		wait_tx(8'h3C);
		@(posedge clock_i);
		mode <= MODE_SIR;
		settle(3);
		check({6'h0, dma_req}, 8'h00);
		@(posedge clock_i);
		dcfg <= 2'b00;
	endtask

	// One enable bit with one source, then the enable is cleared again.
	task automatic irq_case(input aiu_mode_type m, input logic hsel, input int b,
		input logic [5:0] s, input logic exp);
		@(posedge clock_i);
		mode <= m;
		hs_sel <= hsel;
		src <= aiu_src_type'(s);
		wr(OFF_IER, 8'h01 << b);
		settle(2);
		check({7'h0, irq}, {7'h0, exp});
		wr(OFF_IER, 8'h00);
		@(posedge clock_i);
		src <= '0;
		settle(2);
		check({7'h0, irq}, 8'h00);
	endtask

	// Mode-dependent gating of each interrupt enable bit.
	task automatic t_irq();
		irq_case(MODE_SIR, 1'b0, IE_TMR, 6'h20, 1'b1);
		irq_case(MODE_MIR, 1'b0, IE_FSF, 6'h10, 1'b1);
		irq_case(MODE_SIR, 1'b0, IE_FSF, 6'h10, 1'b0);
		irq_case(MODE_ASK, 1'b0, IE_TXTH, 6'h00, 1'b1);
		irq_case(MODE_FIR, 1'b0, IE_DMA, 6'h01, 1'b1);
		chk_rd(OFF_ISR, 8'h32);
		chk_rd(OFF_ISR, 8'h22);
		irq_case(MODE_SIR, 1'b0, IE_DMA, 6'h01, 1'b0);
		irq_case(MODE_SIR, 1'b0, IE_HS, 6'h08, 1'b0);
		irq_case(MODE_SIR, 1'b1, IE_HS, 6'h08, 1'b1);
		irq_case(MODE_SIR, 1'b0, IE_LS, 6'h04, 1'b1);
		irq_case(MODE_ASK, 1'b0, IE_LS, 6'h02, 1'b0);
		irq_case(MODE_RC, 1'b0, IE_LS, 6'h02, 1'b1);
		irq_case(MODE_SIR, 1'b0, IE_TXE, 6'h00, 1'b1);
		irq_case(MODE_SIR, 1'b0, IE_RX, 6'h00, 1'b0);
		i_line.send_rx(8'h41);
		irq_case(MODE_SIR, 1'b0, IE_RX, 6'h00, 1'b1);
		chk_rd(OFF_DATA, 8'h41);
		@(posedge clock_i);
		bank <= 1'b0;
		irq_case(MODE_UART, 1'b0, IE_TMR, 6'h20, 1'b0);
	endtask

	// Reset for ten cycles, then the scenarios in turn.
	initial begin
		repeat (10) @(posedge clock_i);
		rst_n_i <= 1'b1;
		#1;
		t_legacy();
		t_sets();
		t_data();
		t_dma();
		t_irq();
		test_done();
	end
endmodule // tb
